// ### rrce_alu_if.sv
// interface: operand and result of the rotate datapath
`timescale 1ns/100ps
interface rrce_alu_if;
   logic [7:0] operand;
   logic       carry_in;
   logic [7:0] result;
   logic       carry_out;
   logic       neg;
   logic       zero;
   modport core (output operand, output carry_in,
                 input result, input carry_out, input neg, input zero);
   modport alu  (input operand, input carry_in,
                 output result, output carry_out, output neg, output zero);
endinterface : rrce_alu_if

// ### rrce_exec.sv
// top: subroutine return and rotate-through-carry executor with AXI4-Lite registers
`timescale 1ns/100ps
module rrce_exec
   import rrce_pkg::*;
(
   input  wire logic              ref_clk_i,          // core clock
   input  wire logic              nrst_i,             // sync reset, active low
   // AXI4-Lite slave
   input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,     // write address
   input  wire logic              s_axi_awvalid_i,    // write address valid
   output logic                   s_axi_awready_o,    // write address ready
   input  wire logic [31:0]       s_axi_wdata_i,      // write data
   input  wire logic [3:0]        s_axi_wstrb_i,      // write strobes
   input  wire logic              s_axi_wvalid_i,     // write data valid
   output logic                   s_axi_wready_o,     // write data ready
   output logic [1:0]             s_axi_bresp_o,      // write response
   output logic                   s_axi_bvalid_o,     // write response valid
   input  wire logic              s_axi_bready_i,     // write response ready
   input  wire logic [AXI_AW-1:0] s_axi_araddr_i,     // read address
   input  wire logic              s_axi_arvalid_i,    // read address valid
   output logic                   s_axi_arready_o,    // read address ready
   output logic [31:0]            s_axi_rdata_o,      // read data
   output logic [1:0]             s_axi_rresp_o,      // read response
   output logic                   s_axi_rvalid_o,     // read data valid
   input  wire logic              s_axi_rready_i,     // read data ready
   // fetch pipeline
   input  wire logic              instr_valid_i,      // instruction offered
   input  wire logic [15:0]       instr_i,            // instruction word
   output logic                   instr_ready_o,      // taken this clock
   // data register file
   output logic [FADR_W-1:0]      file_addr_o,        // bank and offset
   input  wire logic [7:0]        file_rdata_i,       // read data
   output logic [7:0]             file_wdata_o,       // write data
   output logic                   file_we_o,          // write strobe
   // return stack and program counter
   input  wire logic [PC_W-1:0]   stack_top_entry_i,  // top of stack
   output logic                   stack_pop_o,        // pop strobe
   output logic [PC_W-1:0]        pc_o,               // program counter
   output logic                   pc_load_o           // pc loaded strobe
);
   rrce_phase_t phase;
   rrce_alu_if  alu_bus ();

   rrce_phase_gen u_phase (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .phase_o   (phase)
   );

   rrce_rotate_alu u_alu (
      .alu (alu_bus)
   );

   // bus slave state
   logic              aw_held_reg, aw_held_next;
   logic [AXI_AW-1:0] aw_addr_reg, aw_addr_next;
   logic              w_held_reg,  w_held_next;
   logic [31:0]       w_data_reg,  w_data_next;
   logic              w_lane0_reg, w_lane0_next;
   logic              awready_reg, awready_next;
   logic              wready_reg,  wready_next;
   logic              bvalid_reg,  bvalid_next;
   logic [1:0]        bresp_reg,   bresp_next;
   logic              arready_reg, arready_next;
   logic              rvalid_reg,  rvalid_next;
   logic [1:0]        rresp_reg,   rresp_next;
   logic [31:0]       rdata_reg,   rdata_next;
   logic              wr_fire;
   logic              wr_ok;

   // core state
   rrce_kind_t        kind_reg,        kind_next;
   logic [15:0]       ir_reg,          ir_next;
   logic              nop_reg,         nop_next;
   logic              ready_reg,       ready_next;
   logic [7:0]        operand_reg,     operand_next;
   logic [7:0]        accum_reg,       accum_next;
   logic [7:0]        status_reg,      status_next;
   logic [BANK_W-1:0] bank_select_reg, bank_select_next;
   logic [7:0]        shadow_accumulator_reg, shadow_accumulator_next;
   logic [7:0]        shadow_flags_reg,       shadow_flags_next;
   logic [BANK_W-1:0] shadow_bank_select_reg, shadow_bank_select_next;
   logic [4:0]        pc_upper_latch_reg, pc_upper_latch_next;
   logic [7:0]        pc_high_latch_reg,  pc_high_latch_next;
   logic [PC_W-1:0]   pc_reg,          pc_next;
   logic              pc_load_reg,     pc_load_next;
   logic              pop_reg,         pop_next;
   logic [FADR_W-1:0] faddr_reg,       faddr_next;
   logic [7:0]        fwdata_reg,      fwdata_next;
   logic              fwe_reg,         fwe_next;

   assign alu_bus.operand  = operand_reg;
   assign alu_bus.carry_in = status_reg[FLAG_C];

   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_ok   = wr_fire && rrce_addr_ok(aw_addr_reg) && w_lane0_reg;

   // bus slave: one write and one read at a time
   always_comb begin
      aw_held_next = aw_held_reg;
      aw_addr_next = aw_addr_reg;
      w_held_next  = w_held_reg;
      w_data_next  = w_data_reg;
      w_lane0_next = w_lane0_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      if (s_axi_awvalid_i && awready_reg) begin
         aw_held_next = 1'b1;
         aw_addr_next = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         w_held_next  = 1'b1;
         w_data_next  = s_axi_wdata_i;
         w_lane0_next = s_axi_wstrb_i[0];
      end
      if (bvalid_reg && s_axi_bready_i)
         bvalid_next = 1'b0;
      if (wr_fire) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = rrce_addr_ok(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready_i)
         rvalid_next = 1'b0;
      if (s_axi_arvalid_i && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = rrce_addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr_i)
            OFS_ACCUM:        rdata_next = {24'h000000, accum_reg};
            OFS_STATUS:       rdata_next = {24'h000000, status_reg};
            OFS_BANK_SEL:     rdata_next = {28'h0000000, bank_select_reg};
            OFS_SHADOW_ACCUM: rdata_next = {24'h000000, shadow_accumulator_reg};
            OFS_SHADOW_FLAGS: rdata_next = {24'h000000, shadow_flags_reg};
            OFS_SHADOW_BANK:  rdata_next = {28'h0000000, shadow_bank_select_reg};
            OFS_PC:           rdata_next = {11'h0, pc_reg};
            OFS_PC_UPPER:     rdata_next = {27'h0, pc_upper_latch_reg};
            OFS_PC_HIGH:      rdata_next = {24'h000000, pc_high_latch_reg};
            OFS_EXEC_STAT:    rdata_next = {27'h0, nop_reg, kind_reg, phase};
            default:          rdata_next = 32'h00000000;
         endcase
      end
      awready_next = !aw_held_next && !bvalid_next;
      wready_next  = !w_held_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 6'h00;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_lane0_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h00000000;
      end else begin
         aw_held_reg <= aw_held_next;
         aw_addr_reg <= aw_addr_next;
         w_held_reg  <= w_held_next;
         w_data_reg  <= w_data_next;
         w_lane0_reg <= w_lane0_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
      end
   end

   // core: software writes first, instruction effects override
   always_comb begin
      kind_next               = kind_reg;
      ir_next                 = ir_reg;
      nop_next                = nop_reg;
      operand_next            = operand_reg;
      accum_next              = accum_reg;
      status_next             = status_reg;
      bank_select_next        = bank_select_reg;
      shadow_accumulator_next = shadow_accumulator_reg;
      shadow_flags_next       = shadow_flags_reg;
      shadow_bank_select_next = shadow_bank_select_reg;
      pc_upper_latch_next     = pc_upper_latch_reg;
      pc_high_latch_next      = pc_high_latch_reg;
      pc_next                 = pc_reg;
      faddr_next              = faddr_reg;
      fwdata_next             = fwdata_reg;
      pc_load_next            = 1'b0;
      pop_next                = 1'b0;
      fwe_next                = 1'b0;
      if (wr_ok) begin
         unique case (aw_addr_reg)
            OFS_ACCUM:        accum_next = w_data_reg[7:0];
            OFS_STATUS:       status_next = w_data_reg[7:0];
            OFS_BANK_SEL:     bank_select_next = w_data_reg[BANK_W-1:0];
            OFS_SHADOW_ACCUM: shadow_accumulator_next = w_data_reg[7:0];
            OFS_SHADOW_FLAGS: shadow_flags_next = w_data_reg[7:0];
            OFS_SHADOW_BANK:  shadow_bank_select_next = w_data_reg[BANK_W-1:0];
            OFS_PC_UPPER:     pc_upper_latch_next = w_data_reg[4:0];
            OFS_PC_HIGH:      pc_high_latch_next = w_data_reg[7:0];
            default:          ;
         endcase
      end
      unique case (phase)
         PH_Q1: begin
            kind_next = K_NONE;
            if (nop_reg)
               nop_next = 1'b0;
            else if (instr_valid_i && ready_reg) begin
               kind_next  = rrce_decode(instr_i);
               ir_next    = instr_i;
               faddr_next = rrce_file_addr(instr_i[ROT_A_BIT], instr_i[7:0],
                                           bank_select_reg);
            end
         end
         PH_Q2: begin
            if (kind_reg == K_ROT)
               operand_next = file_rdata_i;
         end
         PH_Q3: begin
            if (kind_reg == K_ROT) begin
               status_next[FLAG_C] = alu_bus.carry_out;
               status_next[FLAG_N] = alu_bus.neg;
               status_next[FLAG_Z] = alu_bus.zero;
               fwdata_next         = alu_bus.result;
               if (ir_reg[ROT_D_BIT])
                  fwe_next = 1'b1;
               else
                  accum_next = alu_bus.result;
            end else if (kind_reg == K_RET) begin
               pc_next      = stack_top_entry_i;
               pc_load_next = 1'b1;
               pop_next     = 1'b1;
               nop_next     = 1'b1;
               if (ir_reg[RET_S_BIT]) begin
                  accum_next       = shadow_accumulator_reg;
                  status_next      = shadow_flags_reg;
                  bank_select_next = shadow_bank_select_reg;
               end
            end
         end
         PH_Q4: ;
      endcase
      ready_next = (phase == PH_Q4) && !nop_next;
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         kind_reg               <= K_NONE;
         ir_reg                 <= RST_INSTR;
         nop_reg                <= 1'b0;
         ready_reg              <= 1'b0;
         operand_reg            <= RST_BYTE;
         accum_reg              <= RST_BYTE;
         status_reg             <= RST_BYTE;
         bank_select_reg        <= 4'h0;
         shadow_accumulator_reg <= RST_BYTE;
         shadow_flags_reg       <= RST_BYTE;
         shadow_bank_select_reg <= 4'h0;
         pc_upper_latch_reg     <= 5'h00;
         pc_high_latch_reg      <= RST_BYTE;
         pc_reg                 <= RST_PC;
         pc_load_reg            <= 1'b0;
         pop_reg                <= 1'b0;
         faddr_reg              <= 12'h000;
         fwdata_reg             <= RST_BYTE;
         fwe_reg                <= 1'b0;
      end else begin
         kind_reg               <= kind_next;
         ir_reg                 <= ir_next;
         nop_reg                <= nop_next;
         ready_reg              <= ready_next;
         operand_reg            <= operand_next;
         accum_reg              <= accum_next;
         status_reg             <= status_next;
         bank_select_reg        <= bank_select_next;
         shadow_accumulator_reg <= shadow_accumulator_next;
         shadow_flags_reg       <= shadow_flags_next;
         shadow_bank_select_reg <= shadow_bank_select_next;
         pc_upper_latch_reg     <= pc_upper_latch_next;
         pc_high_latch_reg      <= pc_high_latch_next;
         pc_reg                 <= pc_next;
         pc_load_reg            <= pc_load_next;
         pop_reg                <= pop_next;
         faddr_reg              <= faddr_next;
         fwdata_reg             <= fwdata_next;
         fwe_reg                <= fwe_next;
      end
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign instr_ready_o   = ready_reg;
   assign file_addr_o     = faddr_reg;
   assign file_wdata_o    = fwdata_reg;
   assign file_we_o       = fwe_reg;
   assign stack_pop_o     = pop_reg;
   assign pc_o            = pc_reg;
   assign pc_load_o       = pc_load_reg;
endmodule : rrce_exec

// ### rrce_exec_checker.sv
// checker: timing and result properties at the executor ports
`timescale 1ns/100ps
module rrce_exec_checker
   import rrce_pkg::*;
(
   input wire logic              ref_clk_i,          // core clock
   input wire logic              nrst_i,             // sync reset, active low
   input wire logic              instr_valid_i,      // instruction offered
   input wire logic [15:0]       instr_i,            // instruction word
   input wire logic              instr_ready_o,      // taken this clock
   input wire logic [FADR_W-1:0] file_addr_o,        // bank and offset
   input wire logic [7:0]        file_rdata_i,       // read data
   input wire logic [7:0]        file_wdata_o,       // write data
   input wire logic              file_we_o,          // write strobe
   input wire logic [PC_W-1:0]   stack_top_entry_i,  // top of stack
   input wire logic              stack_pop_o,        // pop strobe
   input wire logic [PC_W-1:0]   pc_o,               // program counter
   input wire logic              pc_load_o           // pc loaded strobe
);
   logic taken;
   logic rot;
   logic ret;
   assign taken = instr_valid_i && instr_ready_o;
   assign rot   = taken && (instr_i[15:10] == OPC_ROT_HI);
   assign ret   = taken && (instr_i[15:1] == OPC_RET_HI);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_ret_pop: assert property (ret |-> ##3 (stack_pop_o && pc_load_o))
      else $error("return gave no pop and pc load");
   a_pc_from_top: assert property (pc_load_o |-> pc_o == $past(stack_top_entry_i))
      else $error("pc not loaded from stack top");
   a_ret_two_cycles: assert property (stack_pop_o |-> !instr_ready_o[*5] ##1 instr_ready_o)
      else $error("return no-op cycle wrong");
   a_ready_gap: assert property (instr_ready_o |=> !instr_ready_o[*3])
      else $error("instruction ready closer than four clocks");
   a_rot_to_file: assert property (rot && instr_i[ROT_D_BIT] |-> ##3 file_we_o)
      else $error("rotate result not written back");
   a_rot_to_acc: assert property (rot && !instr_i[ROT_D_BIT] |->
      ##3 !file_we_o ##1 !file_we_o)
      else $error("rotate to accumulator wrote file");
   a_rot_data: assert property (file_we_o |->
      file_wdata_o[7:1] == $past(file_rdata_i[6:0], 2))
      else $error("rotated data wrong");
   a_access_bank: assert property (rot && !instr_i[ROT_A_BIT] |=> file_addr_o ==
      {$past(instr_i[7]) ? ACCESS_BANK_HI : ACCESS_BANK_LO, $past(instr_i[7:0])})
      else $error("access bank address wrong");
   a_bank_offset: assert property (rot && instr_i[ROT_A_BIT] |=>
      file_addr_o[7:0] == $past(instr_i[7:0]))
      else $error("banked offset wrong");
endmodule : rrce_exec_checker

// ### rrce_far_model.sv
// partner: data register file and return stack
`timescale 1ns/100ps
module rrce_far_model
   import rrce_pkg::*;
(
   input  wire logic              ref_clk_i,         // core clock
   input  wire logic [FADR_W-1:0] file_addr_i,       // bank and offset
   input  wire logic [7:0]        file_wdata_i,      // write data
   input  wire logic              file_we_i,         // write strobe
   output logic [7:0]             file_rdata_o,      // read data
   input  wire logic              stack_pop_i,       // pop strobe
   output logic [PC_W-1:0]        stack_top_entry_o  // top of stack
);
   logic [7:0]      mem [2**FADR_W];
   logic [PC_W-1:0] top;
   initial begin
      for (int i = 0; i < 2**FADR_W; i++)
         mem[i] = 8'(i * 37 + i / 256 * 101 + 11);
      top = 21'h0ABCDE;
   end
   assign file_rdata_o      = mem[file_addr_i];
   assign stack_top_entry_o = top;
   always @(posedge ref_clk_i) begin
      if (file_we_i)
         mem[file_addr_i] <= file_wdata_i;
      // popped entry gone, show a different value
      if (stack_pop_i)
         top <= ~top;
   end
endmodule : rrce_far_model

// ### rrce_phase_gen.sv
// module: four-phase instruction cycle sequencer
`timescale 1ns/100ps
module rrce_phase_gen
   import rrce_pkg::*;
(
   input  wire logic  ref_clk_i,  // core clock
   input  wire logic  nrst_i,     // sync reset, active low
   output rrce_phase_t phase_o    // current phase
);
   rrce_phase_t phase_reg;
   rrce_phase_t phase_next;

   always_comb begin
      unique case (phase_reg)
         PH_Q1: phase_next = PH_Q2;
         PH_Q2: phase_next = PH_Q3;
         PH_Q3: phase_next = PH_Q4;
         PH_Q4: phase_next = PH_Q1;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i)
         phase_reg <= PH_Q1;
      else
         phase_reg <= phase_next;
   end

   assign phase_o = phase_reg;
endmodule : rrce_phase_gen

// ### rrce_pkg.sv
// package: constants, types and helpers for the return and rotate-through-carry executor
package rrce_pkg;
   // register bus
   localparam int         AXI_AW           = 6;
   localparam logic [5:0] OFS_ACCUM        = 6'h00;
   localparam logic [5:0] OFS_STATUS       = 6'h04;
   localparam logic [5:0] OFS_BANK_SEL     = 6'h08;
   localparam logic [5:0] OFS_SHADOW_ACCUM = 6'h0C;
   localparam logic [5:0] OFS_SHADOW_FLAGS = 6'h10;
   localparam logic [5:0] OFS_SHADOW_BANK  = 6'h14;
   localparam logic [5:0] OFS_PC           = 6'h18;
   localparam logic [5:0] OFS_PC_UPPER     = 6'h1C;
   localparam logic [5:0] OFS_PC_HIGH      = 6'h20;
   localparam logic [5:0] OFS_EXEC_STAT    = 6'h24;
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   // widths
   localparam int PC_W   = 21;
   localparam int BANK_W = 4;
   localparam int FADR_W = 12;

   // opcode fields
   localparam logic [14:0] OPC_RET_HI  = 15'h0009;
   localparam logic [5:0]  OPC_ROT_HI  = 6'h0D;
   localparam int          RET_S_BIT   = 0;
   localparam int          ROT_D_BIT   = 9;
   localparam int          ROT_A_BIT   = 8;

   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 2;
   localparam int FLAG_N = 4;

   // access bank split
   localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
   localparam logic [BANK_W-1:0] ACCESS_BANK_LO = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_BANK_HI = 4'hF;

   // reset values
   localparam logic [7:0]      RST_BYTE = 8'h00;
   localparam logic [PC_W-1:0] RST_PC   = 21'h000000;
   localparam logic [15:0]     RST_INSTR = 16'h0000;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} rrce_phase_t;
   typedef enum logic [1:0] {K_NONE, K_RET, K_ROT} rrce_kind_t;

   function automatic rrce_kind_t rrce_decode(input logic [15:0] op);
      if (op[15:1] == OPC_RET_HI)
         return K_RET;
      else if (op[15:10] == OPC_ROT_HI)
         return K_ROT;
      else
         return K_NONE;
   endfunction : rrce_decode

   function automatic logic rrce_addr_ok(input logic [AXI_AW-1:0] a);
      return (a[1:0] == 2'h0) && (a <= OFS_EXEC_STAT);
   endfunction : rrce_addr_ok

   function automatic logic [FADR_W-1:0] rrce_file_addr(input logic             a_bit,
                                                         input logic [7:0]       f,
                                                         input logic [BANK_W-1:0] bank_sel);
      if (a_bit)
         return {bank_sel, f};
      else if (f < ACCESS_SPLIT)
         return {ACCESS_BANK_LO, f};
      else
         return {ACCESS_BANK_HI, f};
   endfunction : rrce_file_addr
endpackage : rrce_pkg

// ### rrce_rotate_alu.sv
// module: rotate left through carry with flag results
`timescale 1ns/100ps
module rrce_rotate_alu (
   rrce_alu_if.alu alu  // operand in, result and flags out
);
   always_comb begin
      alu.result    = {alu.operand[6:0], alu.carry_in};
      alu.carry_out = alu.operand[7];
      alu.neg       = alu.operand[6];
      alu.zero      = ({alu.operand[6:0], alu.carry_in} == 8'h00);
   end
endmodule : rrce_rotate_alu

// ### tb_rrce_exec.sv
// testbench: random and corner tests of the return and rotate executor
`timescale 1ns/100ps
module tb_rrce_exec;
   import rrce_pkg::*;
   logic        clk = 1'h0, nrst = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0, ivalid = 1'h0;
   logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [15:0] instr = 16'h0000;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid, iready, we, pop, pcload, dd, aa, c;
   logic [11:0] faddr, fa;
   logic [7:0]  frd, fwd, opv, acc, res, f;
   logic [7:0]  v [8];
   logic [3:0]  bk;
   logic [20:0] stop, pc, top;
   logic [5:0]  ofs [8] = '{OFS_ACCUM, OFS_STATUS, OFS_BANK_SEL, OFS_SHADOW_ACCUM,
                            OFS_SHADOW_FLAGS, OFS_SHADOW_BANK, OFS_PC_UPPER, OFS_PC_HIGH};
   logic [7:0]  msk [8] = '{8'hFF, 8'h15, 8'h0F, 8'hFF, 8'h15, 8'h0F, 8'h1F, 8'hFF};
   int          num_errors = 0, samples_checked = 0, cycles = 0;
   always #25 clk = ~clk;
   rrce_exec i_rrce_exec (.ref_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .instr_valid_i(ivalid), .instr_i(instr),
      .instr_ready_o(iready), .file_addr_o(faddr), .file_rdata_i(frd), .file_wdata_o(fwd),
      .file_we_o(we), .stack_top_entry_i(stop), .stack_pop_o(pop), .pc_o(pc),
      .pc_load_o(pcload));
   rrce_far_model i_rrce_far_model (.ref_clk_i(clk), .file_addr_i(faddr),
      .file_wdata_i(fwd), .file_we_i(we), .file_rdata_o(frd), .stack_pop_i(pop),
      .stack_top_entry_o(stop));
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_resp
   task automatic wr(input logic [5:0] a, input logic [31:0] x, output logic [1:0] rs);
      @(posedge clk);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'h0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] x, output logic [1:0] rs);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) begin
            x = rdata;
            rs = rresp;
            rready <= 1'h0;
            break;
         end
      end
   endtask : rd
   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      rd(a, d, r);
      chk_resp(r, RESP_OKAY);
      chk(d, exp);
   endtask : rdchk
   task automatic exec(input logic [15:0] op);
      @(posedge clk);
      ivalid <= 1'h1;
      instr <= op;
      do @(posedge clk); while (iready !== 1'h1);
      ivalid <= 1'h0;
      repeat (4) @(posedge clk);
   endtask : exec
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(79790));
      repeat (16) @(posedge clk);
      nrst <= 1'h1;
      for (int i = 0; i < 9; i++)
         rdchk(6'(i * 4), 32'h0);
      rd(6'h28, d, r);
      chk_resp(r, RESP_SLVERR);
      chk(d, 32'h0);
      wr(6'h02, 32'hFF, r);
      chk_resp(r, RESP_SLVERR);
      wr(OFS_PC, 32'h55, r);
      rdchk(OFS_PC, 32'h0);
      $display("test register_bus done");
      for (int i = 0; i < 24; i++) begin
         {dd, aa} = 2'(i);
         {c, bk, f, acc, opv} = 29'($urandom);
         if (i < 2) c = 1'h0;
         if (i < 3) opv = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'hFF;
         fa = aa ? {bk, f} : {f[7] ? ACCESS_BANK_HI : ACCESS_BANK_LO, f};
         res = {opv[6:0], c};
         wr(OFS_ACCUM, {24'h0, acc}, r);
         wr(OFS_STATUS, {31'h0, c}, r);
         wr(OFS_BANK_SEL, {28'h0, bk}, r);
         i_rrce_far_model.mem[fa] = opv;
         exec({OPC_ROT_HI, dd, aa, f});
         rdchk(OFS_ACCUM, {24'h0, dd ? acc : res});
         chk({24'h0, i_rrce_far_model.mem[fa]}, {24'h0, dd ? res : opv});
         rdchk(OFS_STATUS, {27'h0, res[7], 1'h0, res == 8'h00, 1'h0, opv[7]});
      end
      $display("test rotate done");
      for (int k = 0; k < 4; k++) begin
         top = 21'($urandom);
         for (int i = 0; i < 8; i++) begin
            v[i] = 8'($urandom) & msk[i];
            wr(ofs[i], {24'h0, v[i]}, r);
         end
         i_rrce_far_model.top = top;
         exec({OPC_RET_HI, k[0]});
         for (int i = 0; i < 8; i++)
            rdchk(ofs[i], {24'h0, (k[0] && i < 3) ? v[i + 3] : v[i]});
         rdchk(OFS_PC, {11'h0, top});
      end
      $display("test return done");
      complete_run();
   end
endmodule : tb_rrce_exec
bind rrce_exec rrce_exec_checker i_rrce_exec_checker (.ref_clk_i, .nrst_i, .instr_valid_i,
   .instr_i, .instr_ready_o, .file_addr_o, .file_rdata_i, .file_wdata_o, .file_we_o,
   .stack_top_entry_i, .stack_pop_o, .pc_o, .pc_load_o);
